//--- core/cenc_ctrl_top.sv
// Purpose: register file, comb set selection and the two sample filters
// Assumes: register port and stream are synchronous to clock
// Notes:   read data appears one cycle after reg_rd with reg_rvalid
`timescale 1ns/100ps
module cenc_ctrl_top (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  // standard and pal comb settings from neighbouring logic
  input  wire cenc_pkg::cenc_std_t   vid_std,
  input  wire logic [7:0]            pal_comb_cfg,
  // sample stream
  input  wire logic                  in_valid,
  input  wire logic [7:0]            in_luma,
  input  wire logic [7:0]            in_chroma,
  output logic                       out_valid,
  output logic      [7:0]            out_luma,
  output logic      [7:0]            out_chroma,
  // comb filter controls
  output logic                       comb_pal_sel,
  output cenc_pkg::cenc_bw_t         comb_split_bw,
  output logic                       chroma_comb_on,
  output logic                       chroma_comb_adaptive,
  output logic      [2:0]            chroma_comb_lines,
  output cenc_pkg::cenc_rows_t       chroma_comb_rows,
  output logic                       luma_comb_on,
  output logic                       luma_comb_adaptive,
  output logic      [2:0]            luma_comb_lines,
  output cenc_pkg::cenc_rows_t       luma_comb_rows
);

  cenc_cfg_if cfg ();

  // register file
  logic [7:0] split_r, split_nxt;
  logic [7:0] comb_r, comb_nxt;
  logic [7:0] edge_r, edge_nxt;
  logic [7:0] cth_r, cth_nxt;
  logic [7:0] yth_r, yth_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;
  logic [7:0] status;
  logic       edge_hit, noise_hit;

  // comb control state
  logic                 pal_r, pal_nxt;
  cenc_pkg::cenc_bw_t   bw_r, bw_nxt;
  logic                 con_r, con_nxt, cad_r, cad_nxt;
  logic [2:0]           cln_r, cln_nxt;
  cenc_pkg::cenc_rows_t crw_r, crw_nxt;
  logic                 yon_r, yon_nxt, yad_r, yad_nxt;
  logic [2:0]           yln_r, yln_nxt;
  cenc_pkg::cenc_rows_t yrw_r, yrw_nxt;
  logic [7:0]           src;
  logic [1:0]           nsel;
  logic [2:0]           cmode, ymode;

  always_comb begin
    status = 8'h00;
    status[cenc_pkg::STS_PAL_BIT]   = pal_r;
    status[cenc_pkg::STS_EDGE_BIT]  = edge_hit;
    status[cenc_pkg::STS_NOISE_BIT] = noise_hit;
    split_nxt = split_r;
    comb_nxt  = comb_r;
    edge_nxt  = edge_r;
    cth_nxt   = cth_r;
    yth_nxt   = yth_r;
    // reserved bits are dropped on write, so they always read zero
    if (reg_wr) begin
      case (reg_addr)
        cenc_pkg::ADDR_SPLIT: split_nxt = reg_wdata & cenc_pkg::SPLIT_MASK;
        cenc_pkg::ADDR_COMB:  comb_nxt  = reg_wdata;
        cenc_pkg::ADDR_EDGE:  edge_nxt  = reg_wdata & cenc_pkg::EDGE_MASK;
        cenc_pkg::ADDR_CTH:   cth_nxt   = reg_wdata;
        cenc_pkg::ADDR_YTH:   yth_nxt   = reg_wdata;
        default: ;
      endcase
    end
    // unmapped offsets read zero; data is only meaningful with rvalid
    rvalid_nxt = reg_rd;
    rdata_nxt  = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        cenc_pkg::ADDR_SPLIT: rdata_nxt = split_r;
        cenc_pkg::ADDR_COMB:  rdata_nxt = comb_r;
        cenc_pkg::ADDR_EDGE:  rdata_nxt = edge_r;
        cenc_pkg::ADDR_CTH:   rdata_nxt = cth_r;
        cenc_pkg::ADDR_YTH:   rdata_nxt = yth_r;
        cenc_pkg::ADDR_STAT:  rdata_nxt = status;
        default:              rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      split_r  <= cenc_pkg::SPLIT_RST;
      comb_r   <= cenc_pkg::COMB_RST;
      edge_r   <= cenc_pkg::EDGE_RST;
      cth_r    <= cenc_pkg::CTH_RST;
      yth_r    <= cenc_pkg::YTH_RST;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      split_r  <= split_nxt;
      comb_r   <= comb_nxt;
      edge_r   <= edge_nxt;
      cth_r    <= cth_nxt;
      yth_r    <= yth_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign cfg.steep_en = edge_r[cenc_pkg::EDG_STEEP_BIT];
  assign cfg.blend_en = edge_r[cenc_pkg::EDG_BLEND_BIT];
  assign cfg.sharp    = edge_r[cenc_pkg::EDG_SHARP_LSB +: 2];
  assign cfg.c_th     = cth_r;
  assign cfg.noise_reduce_enable   = edge_r[cenc_pkg::EDG_DNR_BIT];
  assign cfg.y_th     = yth_r;

  // comb selection; re-evaluated every cycle so a standard change
  // takes effect one clock later
  always_comb begin
    pal_nxt = (vid_std != cenc_pkg::STD_NTSC_MJ);
    src     = pal_nxt ? pal_comb_cfg : comb_r;
    nsel    = split_r[cenc_pkg::SPL_NTSC_LSB +: 2];
    if (pal_nxt) begin
      bw_nxt = cenc_pkg::cenc_bw_t'(
                 split_r[cenc_pkg::SPL_PAL_LSB +: 2]);
    end else begin
      case (nsel)
        2'h0:    bw_nxt = cenc_pkg::BW_NARROW;
        2'h3:    bw_nxt = cenc_pkg::BW_WIDE;
        default: bw_nxt = cenc_pkg::BW_MEDIUM;
      endcase
    end
    cmode   = src[cenc_pkg::CMB_CMODE_LSB +: 3];
    ymode   = src[cenc_pkg::CMB_YMODE_LSB +: 3];
    con_nxt = (cmode != cenc_pkg::MODE_OFF);
    cad_nxt = !cmode[2];
    cln_nxt = cenc_pkg::cenc_chroma_lines(cmode,
                src[cenc_pkg::CMB_TAP_LSB +: 2]);
    crw_nxt = cenc_pkg::cenc_rows(cmode);
    yon_nxt = (ymode != cenc_pkg::MODE_OFF);
    yad_nxt = !ymode[2];
    yln_nxt = cenc_pkg::cenc_luma_lines(ymode);
    yrw_nxt = cenc_pkg::cenc_rows(ymode);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pal_r <= 1'b0;
      bw_r  <= cenc_pkg::BW_NARROW;
      con_r <= 1'b0;
      cad_r <= 1'b0;
      cln_r <= cenc_pkg::LINES_NONE;
      crw_r <= cenc_pkg::ROWS_ALL;
      yon_r <= 1'b0;
      yad_r <= 1'b0;
      yln_r <= cenc_pkg::LINES_NONE;
      yrw_r <= cenc_pkg::ROWS_ALL;
    end else begin
      pal_r <= pal_nxt;
      bw_r  <= bw_nxt;
      con_r <= con_nxt;
      cad_r <= cad_nxt;
      cln_r <= cln_nxt;
      crw_r <= crw_nxt;
      yon_r <= yon_nxt;
      yad_r <= yad_nxt;
      yln_r <= yln_nxt;
      yrw_r <= yrw_nxt;
    end
  end

  // both filters take the same strobe, so their outputs stay aligned
  cenc_edge u_edge (
    .clock      (clock),
    .rst        (rst),
    .cfg        (cfg.steep),
    .in_valid   (in_valid),
    .in_chroma  (in_chroma),
    .out_valid  (out_valid),
    .out_chroma (out_chroma),
    .edge_hit   (edge_hit)
  );

  cenc_dnr u_dnr (
    .clock     (clock),
    .rst       (rst),
    .cfg       (cfg.nr),
    .in_valid  (in_valid),
    .in_luma   (in_luma),
    .out_luma  (out_luma),
    .noise_hit (noise_hit)
  );

  assign reg_rdata            = rdata_r;
  assign reg_rvalid           = rvalid_r;
  assign comb_pal_sel         = pal_r;
  assign comb_split_bw        = bw_r;
  assign chroma_comb_on       = con_r;
  assign chroma_comb_adaptive = cad_r;
  assign chroma_comb_lines    = cln_r;
  assign chroma_comb_rows     = crw_r;
  assign luma_comb_on         = yon_r;
  assign luma_comb_adaptive   = yad_r;
  assign luma_comb_lines      = yln_r;
  assign luma_comb_rows       = yrw_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_RST_EDGE: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> edge_r == cenc_pkg::EDGE_RST && cth_r == cenc_pkg::CTH_RST)
    else $error("edge control reset value wrong");
  AST_PAL_SEL: assert property (
    vid_std != cenc_pkg::STD_NTSC_MJ |=> comb_pal_sel)
    else $error("pal set not selected");
  AST_SPLIT_NTSC: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ && split_r[3:2] == 2'h3 && !reg_wr
    ##1 !reg_wr && vid_std == cenc_pkg::STD_NTSC_MJ
    |=> comb_split_bw == cenc_pkg::BW_WIDE)
    else $error("ntsc wide split not decoded");
  AST_CMODE_OFF: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ && comb_r[5:3] == cenc_pkg::MODE_OFF
    |=> !chroma_comb_on && chroma_comb_lines == 3'h0)
    else $error("chroma comb not disabled");
  AST_CFIX_TOP: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ && comb_r == 8'he8
    |=> chroma_comb_lines == 3'h4 && chroma_comb_rows == cenc_pkg::ROWS_TOP)
    else $error("fixed top chroma comb wrong");
  AST_YMODE_ALL: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ && comb_r[2:0] == cenc_pkg::MODE_ALL
    |=> luma_comb_on && !luma_comb_adaptive && luma_comb_lines == 3'h3)
    else $error("fixed all luma comb wrong");
  AST_RD_LAT: assert property (
    reg_rd && reg_addr == cenc_pkg::ADDR_YTH |=> reg_rvalid
    && reg_rdata == $past(yth_r))
    else $error("threshold readback wrong");
  // decode checks for both comb sets and the register port
  AST_NTSC_SEL: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ |=> !comb_pal_sel)
    else $error("ntsc set not selected");
  AST_SPLIT_MED: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ
    && (split_r[cenc_pkg::SPL_NTSC_LSB +: 2] == 2'h1
        || split_r[cenc_pkg::SPL_NTSC_LSB +: 2] == 2'h2)
    |=> comb_split_bw == cenc_pkg::BW_MEDIUM)
    else $error("ntsc medium split not decoded");
  AST_SPLIT_PAL: assert property (
    vid_std != cenc_pkg::STD_NTSC_MJ
    |=> comb_split_bw == $past(split_r[cenc_pkg::SPL_PAL_LSB +: 2]))
    else $error("pal split not decoded");
  AST_CTAP_FIVE: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ
    && comb_r[cenc_pkg::CMB_TAP_LSB +: 2] == 2'h3
    && comb_r[cenc_pkg::CMB_CMODE_LSB +: 3] == cenc_pkg::MODE_ALL
    |=> chroma_comb_lines == 3'h5)
    else $error("five line chroma comb not decoded");
  AST_CMODE_ADAPT: assert property (
    vid_std == cenc_pkg::STD_NTSC_MJ
    && !comb_r[cenc_pkg::CMB_CMODE_LSB + 2]
    |=> chroma_comb_on && chroma_comb_adaptive
        && chroma_comb_rows == cenc_pkg::ROWS_ALL)
    else $error("adaptive chroma comb not decoded");
  AST_PAL_YOFF: assert property (
    vid_std != cenc_pkg::STD_NTSC_MJ
    && pal_comb_cfg[cenc_pkg::CMB_YMODE_LSB +: 3] == cenc_pkg::MODE_OFF
    |=> !luma_comb_on && luma_comb_lines == 3'h0)
    else $error("pal luma comb setting not used");
  AST_WR_EDGE: assert property (
    reg_wr && reg_addr == cenc_pkg::ADDR_EDGE
    |=> edge_r == ($past(reg_wdata) & cenc_pkg::EDGE_MASK))
    else $error("edge control write not stored");
  AST_RD_IDLE: assert property (
    !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read data not idle");
  COV_PAL_SWITCH: cover property (!comb_pal_sel ##1 comb_pal_sel);
  COV_WR_EDGE: cover property (reg_wr && reg_addr == cenc_pkg::ADDR_EDGE);

endmodule

//--- common/cenc_pkg.sv
// Purpose: shared constants, types and decode helpers for the
//          chroma edge, luma noise and comb control block
// Assumes: 8-bit register bus inside the decoder, 8-bit samples
// Notes:   register offsets and field layouts live only here
package cenc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_SPLIT = 8'h19;
  localparam logic [7:0] ADDR_COMB  = 8'h38;
  localparam logic [7:0] ADDR_EDGE  = 8'h4d;
  localparam logic [7:0] ADDR_CTH   = 8'h4e;
  localparam logic [7:0] ADDR_YTH   = 8'h50;
  localparam logic [7:0] ADDR_STAT  = 8'hf0;

  // reset values and writable bits
  localparam logic [7:0] SPLIT_RST  = 8'h01;
  localparam logic [7:0] COMB_RST   = 8'h80;
  localparam logic [7:0] EDGE_RST   = 8'h2e;
  localparam logic [7:0] CTH_RST    = 8'h08;
  localparam logic [7:0] YTH_RST    = 8'h08;
  localparam logic [7:0] SPLIT_MASK = 8'h0f;
  localparam logic [7:0] EDGE_MASK  = 8'h2f;

  // field positions
  localparam int SPL_PAL_LSB   = 0;
  localparam int SPL_NTSC_LSB  = 2;
  localparam int CMB_TAP_LSB   = 6;
  localparam int CMB_CMODE_LSB = 3;
  localparam int CMB_YMODE_LSB = 0;
  localparam int EDG_STEEP_BIT = 0;
  localparam int EDG_BLEND_BIT = 1;
  localparam int EDG_SHARP_LSB = 2;
  localparam int EDG_DNR_BIT   = 5;
  localparam int STS_PAL_BIT   = 0;
  localparam int STS_EDGE_BIT  = 1;
  localparam int STS_NOISE_BIT = 2;

  // sample reset values
  localparam logic [7:0] CHROMA_RST = 8'h80;
  localparam logic [7:0] LUMA_RST   = 8'h00;

  // comb mode codes and line counts
  localparam logic [2:0] MODE_OFF    = 3'h4;
  localparam logic [2:0] MODE_TOP    = 3'h5;
  localparam logic [2:0] MODE_ALL    = 3'h6;
  localparam logic [2:0] MODE_BOT    = 3'h7;
  localparam logic [2:0] LINES_NONE  = 3'h0;
  localparam logic [2:0] LINES_TWO   = 3'h2;
  localparam logic [2:0] LINES_THREE = 3'h3;

  typedef enum logic [2:0] {
    STD_NTSC_MJ   = 3'h0,
    STD_NTSC443   = 3'h1,
    STD_PAL_BGHID = 3'h2,
    STD_PAL_M     = 3'h3,
    STD_PAL_N     = 3'h4,
    STD_PAL_60    = 3'h5
  } cenc_std_t;

  typedef enum logic [1:0] {
    BW_NARROW = 2'h0,
    BW_MEDIUM = 2'h1,
    BW_WIDE   = 2'h2,
    BW_WIDEST = 2'h3
  } cenc_bw_t;

  typedef enum logic [1:0] {
    ROWS_ALL  = 2'h0,
    ROWS_TOP  = 2'h1,
    ROWS_BOT  = 2'h2
  } cenc_rows_t;

  typedef enum logic [1:0] {
    SHARP_MOST   = 2'h0,
    SHARP_SOME   = 2'h1,
    SMOOTH_SOME  = 2'h2,
    SMOOTH_MOST  = 2'h3
  } cenc_sharp_t;

  function automatic logic [7:0] cenc_absdiff(input logic [7:0] a,
                                              input logic [7:0] b);
    return (a >= b) ? (a - b) : (b - a);
  endfunction

  // tap code 00 must not be used; it decodes like 01
  function automatic logic [2:0] cenc_chroma_lines(input logic [2:0] mode,
                                                   input logic [1:0] taps);
    logic [2:0] idx;
    idx = (taps == 2'h0) ? 3'h0 : {1'b0, taps} - 3'h1;
    if (mode == MODE_OFF) return LINES_NONE;
    if (mode == MODE_TOP || mode == MODE_BOT) return LINES_TWO + idx;
    return LINES_THREE + idx;
  endfunction

  function automatic logic [2:0] cenc_luma_lines(input logic [2:0] mode);
    if (mode == MODE_OFF) return LINES_NONE;
    if (mode == MODE_TOP || mode == MODE_BOT) return LINES_TWO;
    return LINES_THREE;
  endfunction

  function automatic cenc_rows_t cenc_rows(input logic [2:0] mode);
    if (mode == MODE_TOP) return ROWS_TOP;
    if (mode == MODE_BOT) return ROWS_BOT;
    return ROWS_ALL;
  endfunction

endpackage

//--- common/cenc_cfg_if.sv
// Purpose: carries filter settings from the register file to the stages
// Assumes: static settings, no handshake needed
// Notes:   one producer, two consumers
`timescale 1ns/100ps
interface cenc_cfg_if;
  logic       steep_en;
  logic       blend_en;
  logic [1:0] sharp;
  logic [7:0] c_th;
  logic       noise_reduce_enable;
  logic [7:0] y_th;

  modport src   (output steep_en, blend_en, sharp, c_th, noise_reduce_enable, y_th);
  modport steep (input steep_en, blend_en, sharp, c_th);
  modport nr    (input noise_reduce_enable, y_th);
endinterface

//--- core/cenc_edge.sv
// Purpose: chroma edge steepening with alpha blend
// Assumes: one new chroma sample per in_valid
// Notes:   output lags by one sample; the next sample is the lookahead
`timescale 1ns/100ps
module cenc_edge (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // settings
  cenc_cfg_if.steep       cfg,
  // chroma stream
  input  wire logic       in_valid,
  input  wire logic [7:0] in_chroma,
  output logic            out_valid,
  output logic [7:0]      out_chroma,
  output logic            edge_hit
);

  logic              [7:0]  cur_r, cur_nxt, out_r, out_nxt;
  logic                     vld_r, vld_nxt, hit_r, hit_nxt;
  logic              [7:0]  step;
  logic                     hit;
  logic signed       [11:0] diff, alpha, prod, mix;

  always_comb begin
    step = cenc_pkg::cenc_absdiff(in_chroma, cur_r);
    hit  = cfg.steep_en && (step >= cfg.c_th);
    case (cfg.sharp)
      cenc_pkg::SHARP_MOST:  alpha = 12'sh004;
      cenc_pkg::SHARP_SOME:  alpha = 12'sh003;
      cenc_pkg::SMOOTH_SOME: alpha = 12'sh002;
      default:               alpha = 12'sh001;
    endcase
    diff = $signed({4'h0, in_chroma}) - $signed({4'h0, cur_r});
    prod = diff * alpha;
    // convex mix stays inside 0..255, so the low byte is exact
    mix  = $signed({4'h0, cur_r}) + (prod >>> 2);
    cur_nxt = cur_r;
    out_nxt = out_r;
    vld_nxt = 1'b0;
    hit_nxt = hit_r;
    if (in_valid) begin
      cur_nxt = in_chroma;
      vld_nxt = 1'b1;
      hit_nxt = hit;
      if (!hit) begin
        out_nxt = cur_r;
      end else if (cfg.blend_en) begin
        out_nxt = mix[7:0];
      end else begin
        out_nxt = in_chroma;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_r <= cenc_pkg::CHROMA_RST;
      out_r <= cenc_pkg::CHROMA_RST;
      vld_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
      out_r <= out_nxt;
      vld_r <= vld_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign out_valid  = vld_r;
  assign out_chroma = out_r;
  assign edge_hit   = hit_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_EDGE_OFF_PASS: assert property (
    in_valid && !cfg.steep_en |=> out_r == $past(cur_r))
    else $error("chroma changed with steepening off");
  AST_EDGE_SMALL: assert property (
    in_valid && (cenc_pkg::cenc_absdiff(in_chroma, cur_r) < cfg.c_th)
    |=> out_r == $past(cur_r) && !hit_r)
    else $error("edge below threshold was steepened");
  AST_EDGE_FULL: assert property (
    in_valid && hit && !cfg.blend_en |=> out_r == $past(in_chroma))
    else $error("unblended steepening wrong");
  AST_BLEND_SMOOTH: assert property (
    in_valid && hit && cfg.blend_en && cfg.sharp == 2'h2
    |=> out_r == 8'((9'($past(cur_r)) + 9'($past(in_chroma))) >> 1))
    else $error("smooth blend not midway");
  COV_EDGE_BLEND: cover property (in_valid && hit && cfg.blend_en);
  COV_EDGE_SKIP: cover property (in_valid && cfg.steep_en && !hit);

endmodule

//--- core/cenc_dnr.sv
// Purpose: luma coring noise reducer
// Assumes: one new luma sample per in_valid
// Notes:   steps within threshold hold the last output level
`timescale 1ns/100ps
module cenc_dnr (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // settings
  cenc_cfg_if.nr          cfg,
  // luma stream
  input  wire logic       in_valid,
  input  wire logic [7:0] in_luma,
  output logic [7:0]      out_luma,
  output logic            noise_hit
);

  logic [7:0] cur_r, cur_nxt, out_r, out_nxt;
  logic       hit_r, hit_nxt;
  logic       kill;

  always_comb begin
    // step size against the last emitted level, sign ignored
    kill = cfg.noise_reduce_enable &&
           (cenc_pkg::cenc_absdiff(cur_r, out_r) <= cfg.y_th);
    cur_nxt = cur_r;
    out_nxt = out_r;
    hit_nxt = hit_r;
    if (in_valid) begin
      cur_nxt = in_luma;
      hit_nxt = kill;
      out_nxt = kill ? out_r : cur_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_r <= cenc_pkg::LUMA_RST;
      out_r <= cenc_pkg::LUMA_RST;
      hit_r <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
      out_r <= out_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign out_luma  = out_r;
  assign noise_hit = hit_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_DNR_BYPASS: assert property (
    in_valid && !cfg.noise_reduce_enable |=> out_r == $past(cur_r) && !hit_r)
    else $error("luma altered while bypassed");
  AST_DNR_REMOVE: assert property (
    in_valid && cfg.noise_reduce_enable
    && cenc_pkg::cenc_absdiff(cur_r, out_r) <= cfg.y_th
    |=> $stable(out_r) && hit_r)
    else $error("small luma step not removed");
  AST_DNR_KEEP: assert property (
    in_valid && cenc_pkg::cenc_absdiff(cur_r, out_r) > cfg.y_th
    |=> out_r == $past(cur_r))
    else $error("large luma step removed");
  COV_DNR_REMOVE: cover property (in_valid && kill ##1 in_valid && !kill);

endmodule

//--- dv/cenc_src_model.sv
// Purpose: upstream decode stage feeding luma/chroma sample pairs
// Assumes: one sample per call, driven off the falling edge
// Notes:   data lines show the inverse between samples so stale
//          values never look valid
`timescale 1ns/100ps
module cenc_src_model (
  // clock
  input  wire logic       clock,
  // sample stream
  output logic            valid,
  output logic [7:0]      luma,
  output logic [7:0]      chroma
);
  initial begin
    valid  = 1'b0;
    luma   = 8'h00;
    chroma = 8'h00;
  end

  task automatic send(input logic [7:0] y, input logic [7:0] c);
    @(negedge clock);
    valid  = 1'b1;
    luma   = y;
    chroma = c;
    @(negedge clock);
    valid  = 1'b0;
    luma   = ~y;
    chroma = ~c;
  endtask
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for the edge, noise and comb control block
// Assumes: strobes one cycle wide, inputs change on the falling edge
// Notes:   expectations are worked out here from the field tables
`timescale 1ns/100ps
module tb;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic [7:0]           reg_addr = 8'h00;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [7:0]           reg_wdata = 8'h00;
  logic [7:0]           reg_rdata;
  logic                 reg_rvalid;
  cenc_pkg::cenc_std_t  vid_std = cenc_pkg::STD_NTSC_MJ;
  logic [7:0]           pal_comb_cfg = 8'ha4;
  logic                 in_valid;
  logic [7:0]           in_luma;
  logic [7:0]           in_chroma;
  logic                 out_valid;
  logic [7:0]           out_luma;
  logic [7:0]           out_chroma;
  logic                 pal_sel;
  cenc_pkg::cenc_bw_t   split_bw;
  logic                 c_on;
  logic                 c_ad;
  logic [2:0]           c_ln;
  cenc_pkg::cenc_rows_t c_rw;
  logic                 y_on;
  logic                 y_ad;
  logic [2:0]           y_ln;
  cenc_pkg::cenc_rows_t y_rw;
  int                   error_cnt = 0;
  int                   n_tests = 0;
  int                   cyc = 0;

  cenc_src_model cenc_src_model_i (.clock(clock), .valid(in_valid),
    .luma(in_luma), .chroma(in_chroma));

  cenc_ctrl_top cenc_ctrl_top_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .vid_std(vid_std), .pal_comb_cfg(pal_comb_cfg), .in_valid(in_valid),
    .in_luma(in_luma), .in_chroma(in_chroma), .out_valid(out_valid),
    .out_luma(out_luma), .out_chroma(out_chroma), .comb_pal_sel(pal_sel),
    .comb_split_bw(split_bw), .chroma_comb_on(c_on),
    .chroma_comb_adaptive(c_ad), .chroma_comb_lines(c_ln),
    .chroma_comb_rows(c_rw), .luma_comb_on(y_on),
    .luma_comb_adaptive(y_ad), .luma_comb_lines(y_ln),
    .luma_comb_rows(y_rw));

  always #4 clock = ~clock;

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end

  task automatic summarize;
    $display("errors %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk_flag("reg_rvalid", 1'b1, reg_rvalid);
    chk("reg_rdata", 16'(e), 16'(reg_rdata));
  endtask

  // output seen on a sample belongs to the sample before it
  task automatic smp(input logic [7:0] y, c, ey, ec);
    cenc_src_model_i.send(y, c);
    chk_flag("out_valid", 1'b1, out_valid);
    chk("out_luma", 16'(ey), 16'(out_luma));
    chk("out_chroma", 16'(ec), 16'(out_chroma));
  endtask

  task automatic t_reset_values;
    rd_chk(cenc_pkg::ADDR_SPLIT, 8'h01);
    rd_chk(cenc_pkg::ADDR_COMB, 8'h80);
    rd_chk(cenc_pkg::ADDR_EDGE, 8'h2e);
    rd_chk(cenc_pkg::ADDR_CTH, 8'h08);
    rd_chk(cenc_pkg::ADDR_YTH, 8'h08);
  endtask

  task automatic t_reg_access;
    wr(cenc_pkg::ADDR_EDGE, 8'hff);
    rd_chk(cenc_pkg::ADDR_EDGE, 8'h2f);
    wr(cenc_pkg::ADDR_SPLIT, 8'hff);
    rd_chk(cenc_pkg::ADDR_SPLIT, 8'h0f);
    wr(cenc_pkg::ADDR_CTH, 8'h00);
    rd_chk(cenc_pkg::ADDR_CTH, 8'h00);
    wr(8'h51, 8'ha5);
    rd_chk(8'h51, 8'h00);
  endtask

  task automatic comb_case(input logic [7:0] cfg, input logic [13:0] e);
    wr(cenc_pkg::ADDR_COMB, cfg);
    rd_chk(cenc_pkg::ADDR_COMB, cfg);
    chk("comb_ctl", 16'(e),
        16'({c_on, c_ad, c_ln, c_rw, y_on, y_ad, y_ln, y_rw}));
  endtask

  task automatic t_comb_modes;
    comb_case(8'h80, 14'h386c);
    comb_case(8'h6f, 14'h24ca);
    comb_case(8'hf6, 14'h2a4c);
    comb_case(8'hfd, 14'h2949);
    comb_case(8'he8, 14'h28ec);
    comb_case(8'ha4, 14'h0000);
  endtask

  task automatic t_std_select;
    logic [1:0] nexp;
    wr(cenc_pkg::ADDR_COMB, 8'h80);
    for (int k = 0; k < 4; k++) begin
      nexp = (k == 3) ? 2'h2 : ((k == 0) ? 2'h0 : 2'h1);
      wr(cenc_pkg::ADDR_SPLIT, 8'(k * 5));
      for (int s = 0; s < 6; s++) begin
        @(negedge clock);
        vid_std = cenc_pkg::cenc_std_t'(s);
        @(negedge clock);
        @(negedge clock);
        chk_flag("comb_pal_sel", s != 0, pal_sel);
        chk("split_bw", 16'((s == 0) ? nexp : k[1:0]),
            16'(split_bw));
        chk_flag("chroma_comb_on", s == 0, c_on);
      end
    end
    @(negedge clock);
    vid_std = cenc_pkg::STD_NTSC_MJ;
  endtask

  task automatic t_noise;
    wr(cenc_pkg::ADDR_EDGE, 8'h0c);
    cenc_src_model_i.send(8'h40, 8'h80);
    smp(8'h42, 8'h80, 8'h40, 8'h80);
    smp(8'h41, 8'h80, 8'h42, 8'h80);
    wr(cenc_pkg::ADDR_YTH, 8'h04);
    wr(cenc_pkg::ADDR_EDGE, 8'h20);
    smp(8'h3e, 8'h80, 8'h42, 8'h80);
    smp(8'h47, 8'h80, 8'h42, 8'h80);
    rd_chk(cenc_pkg::ADDR_STAT, 8'h04);
    smp(8'h40, 8'h80, 8'h47, 8'h80);
    smp(8'h40, 8'h80, 8'h40, 8'h80);
  endtask

  task automatic t_steepen;
    logic [7:0] cur;
    wr(cenc_pkg::ADDR_CTH, 8'h10);
    wr(cenc_pkg::ADDR_EDGE, 8'h01);
    smp(8'h40, 8'h90, 8'h40, 8'h90);
    smp(8'h40, 8'h81, 8'h40, 8'h90);
    smp(8'h40, 8'h71, 8'h40, 8'h71);
    cur = 8'h71;
    // weight a is 4 for code 00 down to 1 for code 11
    for (int s = 3; s >= 0; s--) begin
      wr(cenc_pkg::ADDR_EDGE, 8'h03 | 8'(s << 2));
      smp(8'h40, cur + 8'h10, 8'h40, cur + 8'(16 - 4*s));
      cur = cur + 8'h10;
    end
    rd_chk(cenc_pkg::ADDR_STAT, 8'h02);
    wr(cenc_pkg::ADDR_EDGE, 8'h0e);
    smp(8'h40, 8'h80, 8'h40, 8'hb1);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    t_reset_values();
    t_reg_access();
    t_comb_modes();
    t_std_select();
    t_noise();
    t_steepen();
    summarize();
  end
endmodule
